// ==== pkg/itt_pkg.sv ====
// Constants shared by the interval timer trio and its counter unit.
package itt_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_CLKSEL  = 8'h04;
  localparam logic [7:0] OFF_T0_LOW  = 8'h08;
  localparam logic [7:0] OFF_T0_HIGH = 8'h0C;
  localparam logic [7:0] OFF_T1_DATA = 8'h10;
  localparam logic [7:0] OFF_T2_DATA = 8'h14;
  localparam logic [7:0] OFF_T0_CNT  = 8'h18;
  localparam logic [7:0] OFF_T1_CNT  = 8'h1C;
  localparam logic [7:0] OFF_T2_CNT  = 8'h20;
  localparam logic [7:0] OFF_CAPTURE = 8'h24;
  localparam logic [7:0] OFF_STATUS  = 8'h28;
  localparam logic [7:0] OFF_MASK    = 8'h2C;

  // ----------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------
  localparam int CTRL_T0_RUN   = 0;
  localparam int CTRL_T0_START = 1;
  localparam int CTRL_CAPTURE  = 2;
  localparam int CTRL_T0_EVERY2 = 3;
  localparam int CTRL_T1_RUN   = 4;
  localparam int CTRL_T1_START = 5;
  localparam int CTRL_T2_START = 6;
  localparam int CTRL_W        = 7;

  // ----------------------------------------------------------------
  // Clock select fields and prescaler taps
  // ----------------------------------------------------------------
  localparam int CLKSEL_T0_LSB = 0;
  localparam int CLKSEL_T1_LSB = 4;
  localparam int CLKSEL_T2_LSB = 8;
  localparam int CLKSEL_W      = 11;
  localparam int PS_W          = 13;
  localparam logic [3:0] T0_TAP_HI  = 4'd11;
  localparam logic [2:0] T0_SEL_HI  = 3'd6;
  localparam logic [2:0] T0_SEL_EXT = 3'd7;
  localparam logic [3:0] T1_TAP_GAP = 4'd3;
  localparam logic [3:0] T2_TAP_BASE = 4'd5;

  // ----------------------------------------------------------------
  // Interrupt status bits and reset values
  // ----------------------------------------------------------------
  localparam int IRQ_T0  = 0;
  localparam int IRQ_T1  = 1;
  localparam int IRQ_T2  = 2;
  localparam int IRQ_CAP = 3;
  localparam int IRQ_W   = 4;
  localparam logic [CTRL_W-1:0]   CTRL_RST   = 7'h00;
  localparam logic [CLKSEL_W-1:0] CLKSEL_RST = 11'h000;
  localparam logic [IRQ_W-1:0]    MASK_RST   = 4'h0;

endpackage : itt_pkg

// ==== pkg/itt_cnt_if.sv ====
// Control and result signals between the timer block and one counter unit.
interface itt_cnt_if #(parameter int W = 8);
  logic         tick;
  logic         run;
  logic         clr;
  logic         cmp_en;
  logic [W-1:0] cmp;
  logic [W-1:0] count;
  logic         match;

  modport ctl (output tick, run, clr, cmp_en, cmp, input count, match);
  modport cnt (input tick, run, clr, cmp_en, cmp, output count, match);
endinterface : itt_cnt_if

// ==== hdl/itt_counter.sv ====
// One up-counter with compare-clear and a delayed match pulse.
module itt_counter
  import itt_pkg::*;
#(
  parameter int W = 8
)(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control from the timer block
  itt_cnt_if.cnt   port
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         pend_q;
  logic         pend_d;
  logic         match_q;
  logic         match_d;

  // Match clears at once; the event leaves on the next count clock.
  always_comb
  begin
    cnt_d   = cnt_q;
    pend_d  = pend_q;
    match_d = 1'b0;
    if (port.clr)
    begin
      cnt_d  = '0;
      pend_d = 1'b0;
    end
    else if (port.tick && port.run)
    begin
      if (pend_q)
      begin
        match_d = 1'b1;
        pend_d  = 1'b0;
      end
      if (port.cmp_en && cnt_q == port.cmp)
      begin
        cnt_d  = '0;
        pend_d = 1'b1;
      end
      else
      begin
        cnt_d = W'(cnt_q + 1'b1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q   <= '0;
      pend_q  <= 1'b0;
      match_q <= 1'b0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      pend_q  <= pend_d;
      match_q <= match_d;
    end
  end

  assign port.count = cnt_q;
  assign port.match = match_q;

endmodule // itt_counter

// ==== hdl/itt_timer_trio.sv ====
// Three interval timers with prescaler, event input, capture and APB registers.
//
// Overview of operation
// - Timer0 is a 16-bit up-counter; timer1 and timer2 are 8-bit.
// - Timer0 clocks from prescaler taps 0..5, tap 11 or the event pin.
// - Timer1 clocks only from prescaler taps 0..3 or 7..10.
// - Timer2 clocks only from prescaler taps 5..12.
// - Timer0/1 match clears the counter; interrupt follows on next count clock.
// - Only timer0 may count external events; others use internal taps.
// - Run bits of timer0/1 pause and resume counting, keeping the count.
// - Timer0/1 advance only while run and start/clear are both 1.
// - Capture enable makes timer0 measure the capture pin period, readable.
// - Every count is readable at any time without disturbing it.
// - Reset low halts all counting.
// - Separate compare data for timer0 (four bytes), timer1 (two), timer2 (one).
// - Timer2 match raises its interrupt and clears its counter.
// - Modulo-N interrupt on every match, or every second one when selected.
//
// Local design decisions: the APB register port and the address map.
module itt_timer_trio
  import itt_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins
  input  wire logic        external_event_input,
  input  wire logic        capture_signal_pin,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic tap_pick(input logic [PS_W-1:0] edges, input logic [3:0] idx);
    tap_pick = (idx < 4'(PS_W)) ? edges[idx] : 1'b0;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0]   ctrl_q;
  logic [CTRL_W-1:0]   ctrl_d;
  logic [CLKSEL_W-1:0] clksel_q;
  logic [CLKSEL_W-1:0] clksel_d;
  logic [15:0]         t0_low_q;
  logic [15:0]         t0_low_d;
  logic [15:0]         t0_high_q;
  logic [15:0]         t0_high_d;
  logic [15:0]         t1_data_q;
  logic [15:0]         t1_data_d;
  logic [7:0]          t2_data_q;
  logic [7:0]          t2_data_d;
  logic [15:0]         cap_q;
  logic [15:0]         cap_d;
  logic [IRQ_W-1:0]    sts_q;
  logic [IRQ_W-1:0]    sts_d;
  logic [IRQ_W-1:0]    mask_q;
  logic [IRQ_W-1:0]    mask_d;
  logic                half_q;
  logic                half_d;
  logic [PS_W-1:0]     ps_q;
  logic [PS_W-1:0]     ps_prev_q;
  logic [2:0]          ev_q;
  logic [2:0]          cp_q;
  logic [31:0]         prdata_q;
  logic [31:0]         prdata_d;
  logic                pready_q;
  logic                pready_d;
  logic                pslverr_q;
  logic                pslverr_d;
  logic                irq_q;
  logic                irq_d;

  // ----------------------------------------------------------------
  // Counter units
  // ----------------------------------------------------------------
  itt_cnt_if #(.W(16)) t0_if ();
  itt_cnt_if #(.W(8))  t1_if ();
  itt_cnt_if #(.W(8))  t2_if ();

  itt_counter #(.W(16)) u_t0 (.pclk(pclk), .presetn(presetn), .port(t0_if.cnt));
  itt_counter #(.W(8))  u_t1 (.pclk(pclk), .presetn(presetn), .port(t1_if.cnt));
  itt_counter #(.W(8))  u_t2 (.pclk(pclk), .presetn(presetn), .port(t2_if.cnt));

  // ----------------------------------------------------------------
  // Prescaler and pin synchronisers
  // ----------------------------------------------------------------
  // Both pins pass two flops; the third flop only serves edge detection.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ps_q      <= '0;
      ps_prev_q <= '0;
      ev_q      <= '0;
      cp_q      <= '0;
    end
    else
    begin
      ps_q      <= PS_W'(ps_q + 1'b1);
      ps_prev_q <= ps_q;
      ev_q      <= {ev_q[1:0], external_event_input};
      cp_q      <= {cp_q[1:0], capture_signal_pin};
    end
  end

  logic [PS_W-1:0] ps_rise;
  logic            ev_rise;
  logic            cap_edge;
  logic [2:0]      t0_sel;
  logic [2:0]      t1_sel;
  logic [2:0]      t2_sel;
  logic            t0_match_irq;

  assign ps_rise  = ps_q & ~ps_prev_q;
  assign ev_rise  = ev_q[1] & ~ev_q[2];
  assign cap_edge = ctrl_q[CTRL_CAPTURE] & cp_q[1] & ~cp_q[2];
  assign t0_sel   = clksel_q[CLKSEL_T0_LSB +: 3];
  assign t1_sel   = clksel_q[CLKSEL_T1_LSB +: 3];
  assign t2_sel   = clksel_q[CLKSEL_T2_LSB +: 3];

  // ----------------------------------------------------------------
  // Counter control
  // ----------------------------------------------------------------
  always_comb
  begin
    if (t0_sel == T0_SEL_EXT)
      t0_if.tick = ev_rise;
    else if (t0_sel == T0_SEL_HI)
      t0_if.tick = tap_pick(ps_rise, T0_TAP_HI);
    else
      t0_if.tick = tap_pick(ps_rise, {1'b0, t0_sel});
  end

  // Timer1 skips taps 4..6; codes 4..7 map onto taps 7..10.
  assign t1_if.tick = tap_pick(ps_rise, {1'b0, t1_sel} + (t1_sel[2] ? T1_TAP_GAP : 4'd0));
  assign t2_if.tick = tap_pick(ps_rise, {1'b0, t2_sel} + T2_TAP_BASE);

  assign t0_if.run    = ctrl_q[CTRL_T0_RUN];
  assign t0_if.clr    = ~ctrl_q[CTRL_T0_START] | cap_edge;
  assign t0_if.cmp_en = ~ctrl_q[CTRL_CAPTURE];
  assign t0_if.cmp    = t0_low_q;
  assign t1_if.run    = ctrl_q[CTRL_T1_RUN];
  assign t1_if.clr    = ~ctrl_q[CTRL_T1_START];
  assign t1_if.cmp_en = 1'b1;
  assign t1_if.cmp    = t1_data_q[7:0];
  assign t2_if.run    = 1'b1;
  assign t2_if.clr    = ~ctrl_q[CTRL_T2_START];
  assign t2_if.cmp_en = 1'b1;
  assign t2_if.cmp    = t2_data_q;

  // Every-second mode suppresses alternate timer0 matches.
  assign t0_match_irq = t0_if.match & (~ctrl_q[CTRL_T0_EVERY2] | half_q);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic setup;
  logic wr;
  logic mapped;

  assign setup = psel & ~penable;
  assign wr    = psel & penable & pwrite & pready_q;

  always_comb
  begin
    case (paddr)
      OFF_CTRL, OFF_CLKSEL, OFF_T0_LOW, OFF_T0_HIGH, OFF_T1_DATA, OFF_T2_DATA,
      OFF_T0_CNT, OFF_T1_CNT, OFF_T2_CNT, OFF_CAPTURE, OFF_STATUS, OFF_MASK:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Register next state
  // ----------------------------------------------------------------
  always_comb
  begin
    ctrl_d    = ctrl_q;
    clksel_d  = clksel_q;
    t0_low_d  = t0_low_q;
    t0_high_d = t0_high_q;
    t1_data_d = t1_data_q;
    t2_data_d = t2_data_q;
    mask_d    = mask_q;
    cap_d     = cap_q;
    half_d    = half_q;
    if (wr)
    begin
      case (paddr)
        OFF_CTRL:    ctrl_d    = pwdata[CTRL_W-1:0];
        OFF_CLKSEL:  clksel_d  = pwdata[CLKSEL_W-1:0];
        OFF_T0_LOW:  t0_low_d  = pwdata[15:0];
        OFF_T0_HIGH: t0_high_d = pwdata[15:0];
        OFF_T1_DATA: t1_data_d = pwdata[15:0];
        OFF_T2_DATA: t2_data_d = pwdata[7:0];
        OFF_MASK:    mask_d    = pwdata[IRQ_W-1:0];
        default:     ctrl_d    = ctrl_q;
      endcase
    end
    if (cap_edge)
      cap_d = t0_if.count;
    if (!ctrl_q[CTRL_T0_EVERY2])
      half_d = 1'b0;
    else if (t0_if.match)
      half_d = ~half_q;
  end

  // A hardware event in the clearing cycle survives the write-one clear.
  always_comb
  begin
    sts_d = sts_q;
    if (wr && paddr == OFF_STATUS)
      sts_d = sts_q & ~pwdata[IRQ_W-1:0];
    sts_d[IRQ_T0]  = sts_d[IRQ_T0]  | t0_match_irq;
    sts_d[IRQ_T1]  = sts_d[IRQ_T1]  | t1_if.match;
    sts_d[IRQ_T2]  = sts_d[IRQ_T2]  | t2_if.match;
    sts_d[IRQ_CAP] = sts_d[IRQ_CAP] | cap_edge;
    irq_d = |(sts_d & mask_d);
  end

  // Read data is sampled at setup, so the access phase lasts one cycle.
  always_comb
  begin
    pready_d  = setup;
    pslverr_d = setup & ~mapped;
    prdata_d  = prdata_q;
    if (setup)
    begin
      case (paddr)
        OFF_CTRL:    prdata_d = 32'(ctrl_q);
        OFF_CLKSEL:  prdata_d = 32'(clksel_q);
        OFF_T0_LOW:  prdata_d = 32'(t0_low_q);
        OFF_T0_HIGH: prdata_d = 32'(t0_high_q);
        OFF_T1_DATA: prdata_d = 32'(t1_data_q);
        OFF_T2_DATA: prdata_d = 32'(t2_data_q);
        OFF_T0_CNT:  prdata_d = 32'(t0_if.count);
        OFF_T1_CNT:  prdata_d = 32'(t1_if.count);
        OFF_T2_CNT:  prdata_d = 32'(t2_if.count);
        OFF_CAPTURE: prdata_d = 32'(cap_q);
        OFF_STATUS:  prdata_d = 32'(sts_q);
        OFF_MASK:    prdata_d = 32'(mask_q);
        default:     prdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q    <= CTRL_RST;
      clksel_q  <= CLKSEL_RST;
      t0_low_q  <= '0;
      t0_high_q <= '0;
      t1_data_q <= '0;
      t2_data_q <= '0;
      cap_q     <= '0;
      sts_q     <= '0;
      mask_q    <= MASK_RST;
      half_q    <= 1'b0;
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q     <= 1'b0;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      clksel_q  <= clksel_d;
      t0_low_q  <= t0_low_d;
      t0_high_q <= t0_high_d;
      t1_data_q <= t1_data_d;
      t2_data_q <= t2_data_d;
      cap_q     <= cap_d;
      sts_q     <= sts_d;
      mask_q    <= mask_d;
      half_q    <= half_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q     <= irq_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

endmodule // itt_timer_trio

// ==== test/itt_pin_model.sv ====
// Far-side source model for the event and capture pins.
module itt_pin_model
(
  // Clock
  input  wire logic pclk,
  // Pins
  output logic      external_event_input,
  output logic      capture_signal_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    external_event_input = 1'b0;
    capture_signal_pin   = 1'b0;
  end

  // Pulses stay high four cycles so the two-flop synchroniser sees them.
  task automatic pulse(input bit cap, input int n);
    repeat (n)
    begin
      if (cap)
        capture_signal_pin <= 1'b1;
      else
        external_event_input <= 1'b1;
      repeat (4) @(posedge pclk);
      capture_signal_pin   <= 1'b0;
      external_event_input <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask
endmodule // itt_pin_model

// ==== test/itt_timer_trio_chk.sv ====
// Assertion checker for the bus and interrupt ports of the timer trio.
module itt_timer_trio_chk
  import itt_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins and interrupt
  input wire logic        external_event_input,
  input wire logic        capture_signal_pin,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire logic bus_setup = psel && !penable;

  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready stayed high");
  a_ready_answers: assert property (bus_setup |=> pready)
    else $error("no answer after setup");
  a_ready_cause: assert property (pready |-> $past(bus_setup))
    else $error("pready without setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (bus_setup && !pwrite && paddr > OFF_MASK
    |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_mapped_ok: assert property (bus_setup && paddr <= OFF_MASK && paddr[1:0] == 2'b00
    |=> !pslverr)
    else $error("mapped access refused");
  a_rdata_hold: assert property (!bus_setup |=> $stable(prdata))
    else $error("read data moved outside setup");
  a_mask_quiet: assert property (psel && penable && pready && pwrite && paddr == OFF_MASK
    && pwdata[3:0] == 4'h0 |=> ##1 !irq)
    else $error("irq high with all masked");
endmodule // itt_timer_trio_chk

bind itt_timer_trio itt_timer_trio_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .external_event_input(external_event_input), .capture_signal_pin(capture_signal_pin),
  .irq(irq)
);

// ==== test/testbench.sv ====
// Self-checking bench for the interval timer trio.
module testbench
  import itt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d;
  logic        pready, pslverr, irq, e, ev, cap;
  int          n_mismatch = 0;
  int          check_count = 0;

  always #50 pclk = ~pclk;

  itt_pin_model u_pins (.pclk(pclk), .external_event_input(ev), .capture_signal_pin(cap));

  itt_timer_trio dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_event_input(ev), .capture_signal_pin(cap), .irq(irq)
  );

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Pready and read data are taken at the edge, before that edge updates them.
    // Only the watchdog ends a wait that never sees pready.
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] v);
    apb(1'b0, a, 32'h0000_0000);
    chk(d, v);
  endtask

  task automatic wait_st(input int b);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      n++;
    end
    while (d[b] !== 1'b1 && n < 300);
    chk({31'h0, d[b]}, 32'h1);
  endtask

  // Three tap periods plus one cycle give 3 or 4 ticks; a neighbouring tap gives 1..2 or 6..7.
  task automatic measure(input int sh, input int code, input int tap, input logic [7:0] ca,
                         input logic [31:0] go);
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_CLKSEL, 32'(code) << sh);
    wr(OFF_CTRL, go);
    repeat (3 << (tap + 1)) @(posedge pclk);
    apb(1'b0, ca, 32'h0000_0000);
    chk({31'h0, d >= 3 && d <= 4}, 32'h1);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (98000) @(posedge pclk);
    n_mismatch++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rc(OFF_CTRL, 32'h0000_0000);
    rc(OFF_MASK, 32'h0000_0000);
    rc(OFF_STATUS, 32'h0000_0000);
    rc(OFF_T0_CNT, 32'h0000_0000);
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk({31'h0, e}, 32'h1);
    chk(d, 32'h0000_0000);
    wr(OFF_T0_CNT, 32'h0000_1234);
    rc(OFF_T0_CNT, 32'h0000_0000);
    wr(OFF_T0_LOW, 32'h0000_FFFF);
    wr(OFF_T0_HIGH, 32'h0000_A55A);
    wr(OFF_T1_DATA, 32'h0000_12FF);
    wr(OFF_T2_DATA, 32'h0000_00FF);
    rc(OFF_T0_LOW, 32'h0000_FFFF);
    rc(OFF_T0_HIGH, 32'h0000_A55A);
    rc(OFF_T1_DATA, 32'h0000_12FF);
    rc(OFF_T2_DATA, 32'h0000_00FF);
    for (int c = 0; c < 7; c++)
      measure(CLKSEL_T0_LSB, c, (c == 6) ? 11 : c, OFF_T0_CNT, 32'h0000_0003);
    for (int c = 0; c < 8; c++)
      measure(CLKSEL_T1_LSB, c, (c < 4) ? c : c + 3, OFF_T1_CNT, 32'h0000_0030);
    for (int c = 0; c < 8; c++)
      measure(CLKSEL_T2_LSB, c, c + 5, OFF_T2_CNT, 32'h0000_0040);
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_CLKSEL, 32'h0000_0000);
    wr(OFF_T1_DATA, 32'h0000_0003);
    wr(OFF_MASK, 32'h0000_0002);
    wr(OFF_CTRL, 32'h0000_0030);
    wait_st(IRQ_T1);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_CTRL, 32'h0000_0010);
    rc(OFF_T1_CNT, 32'h0000_0000);
    wr(OFF_MASK, 32'h0000_0000);
    // The write edge also updates irq, so it is looked at one edge later.
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_STATUS, 32'h0000_0002);
    rc(OFF_STATUS, 32'h0000_0000);
    wr(OFF_T1_DATA, 32'h0000_00FF);
    wr(OFF_CTRL, 32'h0000_0030);
    repeat (20) @(posedge pclk);
    wr(OFF_CTRL, 32'h0000_0020);
    apb(1'b0, OFF_T1_CNT, 32'h0000_0000);
    chk({31'h0, d != 0}, 32'h1);
    repeat (20) @(posedge pclk);
    rc(OFF_T1_CNT, d);
    // Event counting with an interrupt on every second match.
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_CLKSEL, 32'h0000_0007);
    wr(OFF_T0_LOW, 32'h0000_0002);
    wr(OFF_CTRL, 32'h0000_000B);
    u_pins.pulse(1'b0, 4);
    repeat (6) @(posedge pclk);
    rc(OFF_STATUS, 32'h0000_0000);
    rc(OFF_T0_CNT, 32'h0000_0001);
    u_pins.pulse(1'b0, 4);
    repeat (6) @(posedge pclk);
    rc(OFF_STATUS, 32'h0000_0001);
    // One word read gives the whole count at once, so both halves agree.
    rc(OFF_T0_CNT, 32'h0000_0002);
    wr(OFF_STATUS, 32'h0000_0001);
    // Timer2 is stopped before its data changes.
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_CLKSEL, 32'h0000_0000);
    wr(OFF_T2_DATA, 32'h0000_0001);
    wr(OFF_MASK, 32'h0000_0004);
    wr(OFF_CTRL, 32'h0000_0040);
    wait_st(IRQ_T2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, OFF_T2_CNT, 32'h0000_0000);
    chk({31'h0, d <= 1}, 32'h1);
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_MASK, 32'h0000_0000);
    wr(OFF_STATUS, 32'h0000_0004);
    // Capture period of 108 cycles at one tick per two cycles.
    wr(OFF_CTRL, 32'h0000_0007);
    u_pins.pulse(1'b1, 1);
    repeat (100) @(posedge pclk);
    u_pins.pulse(1'b1, 1);
    rc(OFF_STATUS, 32'h0000_0008);
    apb(1'b0, OFF_CAPTURE, 32'h0000_0000);
    chk({31'h0, d >= 52 && d <= 55}, 32'h1);
    // Reset in mid-run.
    wr(OFF_CTRL, 32'h0000_0030);
    repeat (20) @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rc(OFF_T1_CNT, 32'h0000_0000);
    rc(OFF_CTRL, 32'h0000_0000);
    final_report();
  end
endmodule // testbench
